// ===== ref_holdover_regs.svh
// Register map, field positions, reset values for the reference selector.
// Assumes a 4-bit word address and 16-bit register data.
`ifndef REF_HOLDOVER_REGS_SVH
`define REF_HOLDOVER_REGS_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_HOLDOFF 4'h1
`define REG_PHASE_WINDOW_THRESHOLD 4'h2
`define REG_STATUS 4'h3
`define REG_LATCHED 4'h4
`define REG_OUT_CFG 4'h5
`define REG_OUT_LVL 4'h6
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_HO_EN_N 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_REVERTIVE_ENABLE 3
`define CTRL_INT_SEL 4
`define CTRL_SRC_INT 5
`define CTRL_PRIO 6
`define CTRL_RESET 16'h0000
`define HOLDOFF_RESET 16'h0000
`define PHASE_WINDOW_THRESHOLD_RESET 15'h0100
`define OUT_CFG_RESET 16'h0000
`define OUT_LVL_RESET 16'h0000
// ----------------------------------------
// Status fields (same positions in latched register)
// ----------------------------------------
`define ST_ACT0 0
`define ST_ACT1 1
`define ST_LOLV 2
`define ST_LOLF 3
`define REF_VALID_NOW 4
`define ST_HOLD 5
`define SELECTED_INPUT_STATUS 6
`endif

// ===== ref_holdover_pkg.sv
// Types shared by the reference selector and its testbench.
// Assumes nothing beyond a SystemVerilog compiler.
package ref_holdover_pkg;
  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_SHORT = 2'b10,
    MODE_AUTO_HOLD = 2'b11
  } switch_mode_t;
  typedef enum logic {
    ST_TRACK = 1'b0,
    ST_HOLDOVER = 1'b1
  } hold_state_t;
endpackage

// ===== holdoff_counter.sv
// Hold-off down-counter with its prescaler.
// Assumes run stays high for a whole holdover episode.
`timescale 1ns/10ps
`default_nettype none
`include "ref_holdover_regs.svh"
module holdoff_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic [7:0] start_value,
  input wire logic [7:0] prescale,
  // Result
  output logic expire
);
  logic [7:0] presc_ff;
  logic [7:0] cnt_ff;
  logic tick;

  assign tick = run && (presc_ff == prescale);

  // ----------------------------------------
  // Prescaler: one tick every prescale+1 cycles
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst || !run || tick)
      presc_ff <= 8'h00; // R15
    else
      presc_ff <= presc_ff + 8'h01; // R12
  end

  // ----------------------------------------
  // Down-counter, reloads on expiry
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_ff <= 8'h00;
      expire <= 1'b0;
    end
    else if (!run)
    begin
      cnt_ff <= start_value;
      expire <= 1'b0;
    end
    else if (tick && cnt_ff <= 8'h01)
    begin
      cnt_ff <= start_value; // R13
      expire <= 1'b1; // R11
    end
    else
    begin
      if (tick)
        cnt_ff <= cnt_ff - 8'h01; // R12
      expire <= 1'b0;
    end
  end

  reload_after_expire_a: assert property (@(posedge clk) disable iff (!nrst) // R13
    expire && run && !tick |-> cnt_ff == $past(start_value))
    else $error("hold-off counter did not reload");
  idle_no_expire_a: assert property (@(posedge clk) disable iff (!nrst) // R15
    !run ##1 !run |-> !expire)
    else $error("hold-off counter expired while stopped");
endmodule // holdoff_counter
`default_nettype wire

// ===== sticky_flags.sv
// Latched fault bits, cleared by writing one.
// Assumes fault is a level, high while the condition lasts.
`timescale 1ns/10ps
`default_nettype none
module sticky_flags #(
  parameter int N = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fault levels and clear strobes
  input wire logic [N-1:0] fault,
  input wire logic [N-1:0] clr,
  // Latched faults
  output logic [N-1:0] flag
);
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      // Set wins over clear, so a lasting fault survives the clear
      always_ff @(posedge clk)
      begin
        if (!nrst)
          flag[i] <= 1'b0;
        else
          flag[i] <= fault[i] | (flag[i] & ~clr[i]); // R24
      end
      fault_sets_a: assert property (@(posedge clk) disable iff (!nrst) // R24
        fault[i] |=> flag[i])
        else $error("latched bit missed a fault");
    end
  endgenerate
endmodule // sticky_flags
`default_nettype wire

// ===== ref_clock_holdover_select.sv
// Reference selection, holdover and lock status for two clock inputs.
// Assumes LOS levels, phase error and divided output clocks are
// synchronous to clk; registers are reached over a plain strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ref_holdover_regs.svh"
// Operation
// (R1) Holdover enable low means manual, reset default
// (R2) Manual select from pin or internal bit
// (R3) Manual change holds until hold-off expiry
// (R4) Manual: holdover flag low during holdover
// (R5) Auto-hold LOS: hold, ref invalid, count
// (R6) Inputs still monitored and flagged in holdover
// (R7) Revalidation during count keeps selection
// (R8) Expiry with active valid: keep, leave hold
// (R9) Expiry with other valid: switch, leave
// (R10) Expiry, none valid: stay in holdover
// (R11) Counter expires on transition to zero
// (R12) Eight-bit counter, prescaled clock, start value
// (R13) Counter reloads start value after expiry
// (R14) New LOS only after latched bit cleared
// (R15) Counter clocked only during holdover episodes
// (R16) Revertive only in auto, higher priority
// (R17) Revertive off by default, no switching
// (R18) Revertive resumes after holdover episode
// (R19) Phase error over threshold means unlocked
// (R20) VCXO lock on momentary and latched bits
// (R21) Synth lock momentary, sticky, lock pin
// (R22) Disabled output holds static level
// (R23) Power-down forces outputs off
// (R24) Latched bits clear by one, fault persists
// (R25) Holdover uses stored tuning word
module ref_clock_holdover_select (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Input monitors and selection pin
  input wire logic [1:0] input_los,
  input wire logic external_ref_select_pin,
  // PLL observation
  input wire logic [14:0] phase_error,
  input wire logic synth_pll_unlocked,
  input wire logic [15:0] live_tuning_word,
  // Output clock sources from the dividers
  input wire logic [3:0] divided_clock,
  // Results
  output logic selected_input,
  output logic holdover_active,
  output logic lock_out,
  output logic [15:0] tuning_word,
  output logic [3:0] clock_output_pair
);
  import ref_holdover_pkg::*;

  logic [15:0] ctrl_ff;
  logic [15:0] holdoff_ff;
  logic [14:0] phase_window_threshold;
  logic [15:0] out_cfg_ff;
  logic [15:0] out_lvl_ff;
  hold_state_t state_ff;
  logic pending_ff;
  logic ref_valid_now;
  logic holdover_inactive_now;
  logic vcxo_pll_locked_now;
  logic synth_pll_locked_now;
  logic [15:0] held_word_ff;
  logic [4:0] fault;
  logic [4:0] clr;
  logic [4:0] latched;
  logic expire;
  logic holdoff_run;
  logic holdover_mode_enable_n;
  switch_mode_t switch_mode_select;
  logic revertive_enable;
  logic manual_choice;
  logic preferred;
  logic auto_mode;
  logic auto_hold;
  logic [1:0] los_event;
  logic [1:0] input_active_now;
  logic [15:0] status_word;
  logic [15:0] latched_word;

  assign holdover_mode_enable_n = ctrl_ff[`CTRL_HO_EN_N];
  assign switch_mode_select = switch_mode_t'(ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  assign revertive_enable = ctrl_ff[`CTRL_REVERTIVE_ENABLE];
  assign preferred = ctrl_ff[`CTRL_PRIO];
  // Manual source: internal bit or external pin
  assign manual_choice = ctrl_ff[`CTRL_SRC_INT] ? ctrl_ff[`CTRL_INT_SEL]
                                                : external_ref_select_pin; // R2
  assign auto_hold = holdover_mode_enable_n && (switch_mode_select == MODE_AUTO_HOLD);
  assign auto_mode = holdover_mode_enable_n &&
                     ((switch_mode_select == MODE_AUTO) || auto_hold);
  assign input_active_now = ~input_los; // R6
  // An input raises an event only while its latched LOS bit is clear
  assign los_event = input_los & ~latched[1:0]; // R14
  assign holdoff_run = (state_ff == ST_HOLDOVER); // R15

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_ff <= `CTRL_RESET; // R1 R17
      holdoff_ff <= `HOLDOFF_RESET;
      phase_window_threshold <= `PHASE_WINDOW_THRESHOLD_RESET;
      out_cfg_ff <= `OUT_CFG_RESET;
      out_lvl_ff <= `OUT_LVL_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `REG_CTRL: ctrl_ff <= reg_wdata;
        `REG_HOLDOFF: holdoff_ff <= reg_wdata;
        `REG_PHASE_WINDOW_THRESHOLD: phase_window_threshold <= reg_wdata[14:0];
        `REG_OUT_CFG: out_cfg_ff <= reg_wdata;
        `REG_OUT_LVL: out_lvl_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Selection state machine
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_ff <= ST_TRACK;
      selected_input <= 1'b0;
      pending_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_TRACK:
        begin
          if (!holdover_mode_enable_n)
          begin
            if (manual_choice != selected_input)
            begin
              state_ff <= ST_HOLDOVER; // R3
              pending_ff <= manual_choice;
            end
          end
          else if (auto_hold && los_event[selected_input])
            state_ff <= ST_HOLDOVER; // R5
          else if (switch_mode_select == MODE_AUTO && input_los[selected_input]
                   && !input_los[~selected_input])
            selected_input <= ~selected_input;
          else if (!holdover_mode_enable_n || switch_mode_select == MODE_SHORT)
            selected_input <= manual_choice;
          else if (auto_mode && revertive_enable && selected_input != preferred
                   && !input_los[preferred])
            selected_input <= preferred; // R16 R18
        end
        ST_HOLDOVER:
        begin
          // Selection frozen until expiry; revertive ignored here
          if (expire)
          begin
            if (!auto_hold)
            begin
              selected_input <= pending_ff; // R3
              state_ff <= ST_TRACK;
            end
            else if (!input_los[selected_input])
              state_ff <= ST_TRACK; // R8
            else if (!input_los[~selected_input])
            begin
              selected_input <= ~selected_input; // R9
              state_ff <= ST_TRACK;
            end
            // Otherwise stay; the counter reloads and runs again
          end // R7 R10
        end
        default: state_ff <= ST_TRACK;
      endcase
    end
  end

  holdoff_counter u_holdoff (
    .clk(clk),
    .nrst(nrst),
    .run(holdoff_run),
    .start_value(holdoff_ff[7:0]),
    .prescale(holdoff_ff[15:8]),
    .expire(expire)
  );

  // ----------------------------------------
  // Momentary status
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ref_valid_now <= 1'b0;
      holdover_inactive_now <= 1'b1;
      vcxo_pll_locked_now <= 1'b0;
      synth_pll_locked_now <= 1'b0;
    end
    else
    begin
      if (auto_hold)
        ref_valid_now <= (state_ff == ST_TRACK) && !los_event[selected_input]
                         || (state_ff == ST_HOLDOVER) && expire
                            && (input_los != 2'b11); // R5 R8 R9 R10
      else
        ref_valid_now <= !input_los[selected_input];
      holdover_inactive_now <= (state_ff != ST_HOLDOVER); // R4
      vcxo_pll_locked_now <= (phase_error <= phase_window_threshold); // R19
      synth_pll_locked_now <= !synth_pll_unlocked; // R21
    end
  end

  // ----------------------------------------
  // Latched status, write one to clear
  // ----------------------------------------
  assign fault = {~ref_valid_now, ~synth_pll_locked_now, ~vcxo_pll_locked_now,
                  input_los}; // R6 R20 R21
  assign clr = (reg_wr && reg_addr == `REG_LATCHED) ? reg_wdata[4:0] : 5'h00; // R24

  sticky_flags #(
    .N(5)
  ) u_sticky (
    .clk(clk),
    .nrst(nrst),
    .fault(fault),
    .clr(clr),
    .flag(latched)
  );

  assign status_word = {9'h000, (holdoff_run && !auto_hold) ? pending_ff : selected_input,
                        holdover_inactive_now, ref_valid_now, synth_pll_locked_now,
                        vcxo_pll_locked_now, input_active_now}; // R4
  // Latched bits read in the active sense: one means no fault seen
  assign latched_word = {11'h000, ~latched};

  // ----------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= ctrl_ff;
        `REG_HOLDOFF: reg_rdata <= holdoff_ff;
        `REG_PHASE_WINDOW_THRESHOLD: reg_rdata <= {1'b0, phase_window_threshold};
        `REG_STATUS: reg_rdata <= status_word;
        `REG_LATCHED: reg_rdata <= latched_word;
        `REG_OUT_CFG: reg_rdata <= out_cfg_ff;
        `REG_OUT_LVL: reg_rdata <= out_lvl_ff;
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // ----------------------------------------
  // Pin outputs and holdover tuning word
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      holdover_active <= 1'b0;
      lock_out <= 1'b0;
    end
    else
    begin
      holdover_active <= (state_ff == ST_HOLDOVER);
      lock_out <= vcxo_pll_locked_now && synth_pll_locked_now; // R21
    end
  end

  // Stored word tracks the loop only outside holdover, in ST_TRACK
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      held_word_ff <= 16'h0000;
      tuning_word <= 16'h0000;
    end
    else
    begin
      if (state_ff == ST_TRACK)
        held_word_ff <= live_tuning_word;
      tuning_word <= (state_ff == ST_HOLDOVER) ? held_word_ff : live_tuning_word; // R25
    end
  end

  // Config: [3:0] enable, [7:4] output power-down, [9:8] channel power-down
  genvar q;
  generate
    for (q = 0; q < 4; q++)
    begin : g_out
      always_ff @(posedge clk)
      begin
        if (!nrst)
          clock_output_pair[q] <= 1'b0;
        else if (out_cfg_ff[4 + q] || out_cfg_ff[8 + q / 2])
          clock_output_pair[q] <= 1'b0; // R23
        else if (!out_cfg_ff[q])
          clock_output_pair[q] <= out_lvl_ff[q]; // R22
        else
          clock_output_pair[q] <= divided_clock[q];
      end
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence los_hit_s;
    auto_hold && state_ff == ST_TRACK && los_event[selected_input];
  endsequence
  sequence hold_entered_s;
    state_ff == ST_HOLDOVER && !ref_valid_now;
  endsequence

  reset_mode_manual_a: assert property ($rose(nrst) |-> !holdover_mode_enable_n) // R1
    else $error("reset did not select manual mode");
  manual_change_hold_a: assert property ( // R3
    !holdover_mode_enable_n && state_ff == ST_TRACK && manual_choice != selected_input
    |=> state_ff == ST_HOLDOVER ##1 !holdover_inactive_now)
    else $error("manual change did not enter holdover");
  los_holdover_a: assert property (los_hit_s |=> hold_entered_s) // R5
    else $error("loss on active input did not enter holdover");
  hold_sel_frozen_a: assert property ( // R7
    state_ff == ST_HOLDOVER && !expire |=> $stable(selected_input))
    else $error("selection changed during hold-off");
  expiry_failover_a: assert property ( // R9
    auto_hold && state_ff == ST_HOLDOVER && expire && input_los == {selected_input, ~selected_input}
    |=> selected_input != $past(selected_input) && ref_valid_now && state_ff == ST_TRACK)
    else $error("failover at expiry missing");
  expiry_none_valid_a: assert property ( // R10
    auto_hold && state_ff == ST_HOLDOVER && expire && input_los == 2'b11
    |=> state_ff == ST_HOLDOVER && !ref_valid_now ##1 latched[4])
    else $error("left holdover with no valid input");
  revert_off_a: assert property ( // R17
    auto_mode && state_ff == ST_TRACK && !revertive_enable && !input_los[selected_input]
    |=> $stable(selected_input))
    else $error("switched with revertive disabled");
  lock_window_a: assert property ( // R19
    phase_error > phase_window_threshold |=> !vcxo_pll_locked_now ##1 !lock_out)
    else $error("phase error outside window not reported");
  power_down_a: assert property ( // R23
    out_cfg_ff[4] || out_cfg_ff[8] |=> !clock_output_pair[0])
    else $error("powered-down output not off");
endmodule // ref_clock_holdover_select
`default_nettype wire

// ===== tb_ref_clock_holdover_select.sv
// Self-checking bench for the reference selector: register port, holdover, lock, outputs.
// Assumes the design files and the register header are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "ref_holdover_regs.svh"
`define CHK(a, e) \
  begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module tb_ref_clock_holdover_select;
  import ref_holdover_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, pin, synth_unl, sel, hold, lock;
  logic [3:0] addr, dclk, outp;
  logic [15:0] wdata, rdata, live, tword, d;
  logic [1:0] los;
  logic [14:0] perr;
  int bad_count, samples_checked, n1;

  ref_clock_holdover_select DUT (
    .clk(clk), .nrst(nrst),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .input_los(los), .external_ref_select_pin(pin),
    .phase_error(perr), .synth_pll_unlocked(synth_unl), .live_tuning_word(live),
    .divided_clock(dclk),
    .selected_input(sel), .holdover_active(hold), .lock_out(lock),
    .tuning_word(tword), .clock_output_pair(outp)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic set_los(input logic [1:0] v);
    @(posedge clk);
    los <= v;
  endtask

  // Bounded wait on the holdover flag, n returns the cycles spent
  task automatic wait_hold(input logic v, output int n);
    n = 0;
    while (hold !== v && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (hold !== v)
    begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, hold, v);
      end_sim();
    end
  endtask

  // Prescale 3, start 8: about eight ticks of four cycles
  task automatic hold_len;
    wait_hold(1'b1, n1);
    wait_hold(1'b0, n1);
    `CHK((n1 >= 28) && (n1 <= 40), 1'b1)
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    los = 2'b00;
    pin = 1'b0;
    perr = 15'h0000;
    synth_unl = 1'b0;
    live = 16'h1234;
    dclk = 4'hA;
    bad_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(`REG_CTRL); `CHK(d, `CTRL_RESET)
    rd(`REG_HOLDOFF); `CHK(d, `HOLDOFF_RESET)
    rd(`REG_PHASE_WINDOW_THRESHOLD); `CHK(d[14:0], `PHASE_WINDOW_THRESHOLD_RESET)
    rd(`REG_OUT_CFG); `CHK(d, `OUT_CFG_RESET)
    `CHK(outp, 4'h0)
    wr(4'hF, 16'hFFFF);
    rd(4'hF); `CHK(d, 16'h0000)
    wr(`REG_STATUS, 16'h0000);
    wr(`REG_LATCHED, 16'h001F);
    rd(`REG_STATUS); `CHK(d, 16'h003F)
    rd(`REG_LATCHED); `CHK(d, 16'h001F)
    // Manual switch by pin, then back with a status look mid-holdover
    wr(`REG_HOLDOFF, 16'h0308);
    @(posedge clk);
    pin <= 1'b1;
    hold_len();
    `CHK(sel, 1'b1)
    @(posedge clk);
    pin <= 1'b0;
    wait_hold(1'b1, n1);
    `CHK(sel, 1'b1)
    rd(`REG_STATUS); `CHK(d[6:4], 3'b001)
    wait_hold(1'b0, n1);
    `CHK(sel, 1'b0)
    // Auto with holdover, both inputs lost, then the other returns
    wr(`REG_CTRL, 16'h0007);
    wr(`REG_LATCHED, 16'h001F);
    set_los(2'b01);
    wait_hold(1'b1, n1);
    @(posedge clk);
    live <= 16'h5678;
    rd(`REG_STATUS); `CHK(d[5:4], 2'b00)
    `CHK(d[0], 1'b0)
    rd(`REG_LATCHED); `CHK(d[4], 1'b0)
    `CHK(tword, 16'h1234)
    set_los(2'b11);
    rd(`REG_STATUS); `CHK(d[1:0], 2'b00)
    settle(60);
    `CHK(hold, 1'b1)
    `CHK(sel, 1'b0)
    wr(`REG_LATCHED, 16'h0010);
    rd(`REG_LATCHED); `CHK(d[4], 1'b0)
    set_los(2'b01);
    wait_hold(1'b0, n1);
    `CHK(sel, 1'b1)
    rd(`REG_STATUS); `CHK(d[6:4], 3'b111)
    // Active input returns during countdown with the other valid too
    set_los(2'b00);
    wr(`REG_LATCHED, 16'h001F);
    set_los(2'b10);
    wait_hold(1'b1, n1);
    set_los(2'b00);
    rd(`REG_STATUS); `CHK(d[1], 1'b1)
    `CHK(sel, 1'b1)
    wait_hold(1'b0, n1);
    `CHK(sel, 1'b1)
    `CHK(tword, 16'h5678)
    // Latch not yet cleared, so a new loss must not start holdover
    set_los(2'b10);
    set_los(2'b00);
    settle(4);
    `CHK(hold, 1'b0)
    wr(`REG_LATCHED, 16'h001F);
    rd(`REG_LATCHED); `CHK(d[4:0], 5'h1F)
    // Revertive off, then on with input 0 preferred
    set_los(2'b01);
    set_los(2'b00);
    settle(8);
    `CHK(sel, 1'b1)
    // Preferred input still lost when revertive is enabled, so no switch yet
    set_los(2'b01);
    wr(`REG_CTRL, 16'h000F);
    settle(4);
    `CHK(sel, 1'b1)
    set_los(2'b00);
    settle(8);
    `CHK({hold, sel}, 2'b00)
    wr(`REG_LATCHED, 16'h001F);
    set_los(2'b10);
    set_los(2'b00);
    settle(8);
    `CHK(sel, 1'b0)
    // Plain automatic and short-term modes switch without holdover
    wr(`REG_CTRL, 16'h0003);
    wr(`REG_LATCHED, 16'h001F);
    set_los(2'b01);
    settle(8);
    `CHK({hold, sel}, 2'b01)
    set_los(2'b00);
    wr(`REG_CTRL, 16'h0025);
    settle(8);
    `CHK({hold, sel}, 2'b00)
    // Manual from the internal bit, counter reloaded
    wr(`REG_CTRL, 16'h0030);
    hold_len();
    `CHK(sel, 1'b1)
    // ----------------------------------------
    // Lock status
    // ----------------------------------------
    wr(`REG_PHASE_WINDOW_THRESHOLD, 16'h0010);
    @(posedge clk);
    perr <= 15'h0011;
    rd(`REG_STATUS); `CHK(d[2], 1'b0)
    `CHK(lock, 1'b0)
    @(posedge clk);
    perr <= 15'h0010;
    rd(`REG_STATUS); `CHK(d[2], 1'b1)
    rd(`REG_LATCHED); `CHK(d[2], 1'b0)
    @(posedge clk);
    synth_unl <= 1'b1;
    wr(`REG_LATCHED, 16'h0008);
    rd(`REG_LATCHED); `CHK(d[3], 1'b0)
    rd(`REG_STATUS); `CHK(d[3], 1'b0)
    `CHK(lock, 1'b0)
    @(posedge clk);
    synth_unl <= 1'b0;
    wr(`REG_LATCHED, 16'h001F);
    rd(`REG_LATCHED); `CHK(d[3:2], 2'b11)
    `CHK(lock, 1'b1)
    // ----------------------------------------
    // Output gating
    // ----------------------------------------
    wr(`REG_OUT_LVL, 16'h0005);
    settle(2);
    `CHK(outp, 4'h5)
    wr(`REG_OUT_CFG, 16'h0003);
    settle(2);
    `CHK(outp, 4'h6)
    wr(`REG_OUT_CFG, 16'h021F);
    settle(2);
    `CHK(outp, 4'h2)
    end_sim();
  end
endmodule // tb_ref_clock_holdover_select
`default_nettype wire
